// file: src/pbs_pkg.sv
// Constants and carrier types for the buffered-update sync block
package pbs_pkg;

	// Bus and counter widths
	localparam int PBS_AW = 3;
	localparam int PBS_DW = 8;
	localparam int PBS_CW = 16;
	localparam int PBS_NTRIG = 3;

	// Register offsets
	localparam logic [PBS_AW-1:0] PBS_A_CFG = 3'h0;
	localparam logic [PBS_AW-1:0] PBS_A_TRIG = 3'h1;
	localparam logic [PBS_AW-1:0] PBS_A_MASKBUF = 3'h2;
	localparam logic [PBS_AW-1:0] PBS_A_MASK = 3'h3;
	localparam logic [PBS_AW-1:0] PBS_A_STAT = 3'h4;

	// Boundary step size
	localparam logic [PBS_CW-1:0] PBS_STEP = 16'h0001;

	// Configuration register, msb first
	typedef struct packed {
		logic dual_capture_enable;
		logic enhanced_feature_enable;
		logic compare_sync_enable;
		logic mask_sync_enable;
		logic sync_trigger_source_select;
		logic counter_reload_on_trigger;
		logic max_boundary_select;
		logic min_boundary_select;
	} pbs_cfg_t;

	// Trigger and mode register, msb first
	typedef struct packed {
		logic [1:0] rsvd;
		logic combine;
		logic center_aligned_select;
		logic sw_sync_request;
		logic [PBS_NTRIG-1:0] hw_trigger_enable;
	} pbs_trig_t;

	// Status register, msb first
	typedef struct packed {
		logic [4:0] rsvd;
		logic combined;
		logic pend_sw;
		logic pend;
	} pbs_stat_t;

	// Counter state coming from the timer
	typedef struct packed {
		logic [PBS_CW-1:0] counter_value;
		logic [PBS_CW-1:0] period_value;
		logic [PBS_CW-1:0] counter_initial_value;
	} pbs_cnt_t;

	// Load and reload strobes going to the timer
	typedef struct packed {
		logic period_load;
		logic cnt_reload;
		logic force_init_out;
	} pbs_strobe_t;

	localparam pbs_cfg_t PBS_CFG_RST = 8'h00;
	localparam pbs_strobe_t PBS_STB_RST = 3'h0;
	localparam logic [PBS_DW-1:0] PBS_ZERO = 8'h00;

endpackage

// file: src/pbs_sync.sv
// Buffered-register and counter synchronization of a PWM timer
//
// Contract
// - Sample three hw triggers; enabled rising edge syncs
// - Enable clears on zero write or detection
// - Trigger with enable-setting write: sync, stays set
// - Writing one requests sw sync; cleared on completion
// - New sw write beats its clear
// - Min boundary: wrap or step to initial
// - Max boundary: step from period minus one
// - No boundary selected: no deferred loads
// - Both selected: first boundary wins
// - Boundary selects changed only by software
// - Period load deferred to boundary after trigger
// - Counter_reload_on_trigger, source zero: period loads at trigger
// - Source select one: only sw starts period load
// - Compare load needs full buffer, sync enable
// - Mask buffer copies each clock when unsynced
// - Synced mask loads on any enabled trigger
// - Source select one: mask loads on hw only
// - Counter reload; without counter_reload_on_trigger only at wrap
// - Counter_reload_on_trigger, source zero: reload on any trigger
// - Counter_reload_on_trigger, source one: reload on hw only
// - Sync works only in combined mode
// - Combined mode needs four control bits
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module pbs_sync #(
	parameter int NCH = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	// Register port
	input wire logic [pbs_pkg::PBS_AW-1:0] i_addr,
	input wire logic [pbs_pkg::PBS_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [pbs_pkg::PBS_DW-1:0] o_rdata,
	// Trigger sources
	input wire logic [pbs_pkg::PBS_NTRIG-1:0] i_hw_trig,
	// Timer counter state and buffer status
	input wire pbs_pkg::pbs_cnt_t i_cnt,
	input wire logic i_period_full,
	input wire logic [NCH-1:0] i_cmp_full,
	// Load strobes and mask
	output pbs_pkg::pbs_strobe_t o_stb,
	output logic [NCH-1:0] o_cmp_load,
	output logic [NCH-1:0] o_output_mask
);
	import pbs_pkg::*;

	typedef struct packed {
		pbs_cfg_t cfg;
		pbs_trig_t trig;
		logic [NCH-1:0] mbuf;
		logic [NCH-1:0] mask;
		logic [NCH-1:0] cmp_ld;
		logic [PBS_NTRIG-1:0] trig_prev;
		logic [PBS_CW-1:0] cnt_prev;
		logic prev_ok;
		logic pend;
		logic pend_sw;
		logic stb_sw;
		pbs_strobe_t stb;
		logic [PBS_DW-1:0] rdata;
	} pbs_state_t;

	localparam pbs_state_t PBS_ST_RST = '0;

	pbs_state_t s_q;
	pbs_state_t s_d;

	function automatic logic hit(input logic [PBS_AW-1:0] a,
		input logic [PBS_AW-1:0] off);
		hit = (a == off);
	endfunction

	logic combined;
	logic wr_cfg;
	logic wr_trig;
	pbs_trig_t wtrig;
	logic [PBS_NTRIG-1:0] edge_hw;
	logic [PBS_NTRIG-1:0] hw_fire;
	logic any_hw;
	logic sw_fire;
	logic any_trig;
	logic imm;
	logic trig_for_load;
	logic at_min;
	logic at_max;
	logic bnd;
	logic deferred;
	logic ld_now;
	logic wrap;
	logic reload;
	pbs_stat_t stat;

	always_comb begin
		combined = s_q.cfg.enhanced_feature_enable
			& ~s_q.cfg.dual_capture_enable
			& s_q.trig.combine & ~s_q.trig.center_aligned_select;
		wr_cfg = i_wr & hit(i_addr, PBS_A_CFG);
		wr_trig = i_wr & hit(i_addr, PBS_A_TRIG);
		wtrig = pbs_trig_t'(i_wdata);
		edge_hw = i_hw_trig & ~s_q.trig_prev;
		// enable may come with the same write
		hw_fire = edge_hw & (s_q.trig.hw_trigger_enable
			| (wr_trig ? wtrig.hw_trigger_enable : '0))
			& {PBS_NTRIG{combined}};
		any_hw = |hw_fire;
		// writing one is the sw event
		sw_fire = wr_trig & wtrig.sw_sync_request & combined;
		any_trig = any_hw | sw_fire;
		imm = ~s_q.cfg.sync_trigger_source_select
			& s_q.cfg.counter_reload_on_trigger;
		trig_for_load = s_q.cfg.sync_trigger_source_select ?
			sw_fire : any_trig;
		if (s_q.trig.center_aligned_select) begin
			at_min = (s_q.cnt_prev == i_cnt.counter_initial_value
				+ PBS_STEP)
				&& (i_cnt.counter_value
				== i_cnt.counter_initial_value);
		end else begin
			at_min = (s_q.cnt_prev == i_cnt.period_value)
				&& (i_cnt.counter_value
				== i_cnt.counter_initial_value);
		end
		at_max = (s_q.cnt_prev == i_cnt.period_value - PBS_STEP)
			&& (i_cnt.counter_value == i_cnt.period_value);
		// either selected boundary, first one wins
		bnd = s_q.prev_ok & combined
			& ((s_q.cfg.min_boundary_select & at_min)
			| (s_q.cfg.max_boundary_select & at_max));
		// deferred load at boundary after trigger
		deferred = s_q.pend & bnd & ~imm;
		// counter_reload_on_trigger with source zero loads at once
		ld_now = imm ? any_trig : deferred;
		wrap = s_q.prev_ok && (s_q.cnt_prev == i_cnt.period_value)
			&& (i_cnt.counter_value == i_cnt.counter_initial_value);
		if (s_q.cfg.counter_reload_on_trigger) begin
			reload = s_q.cfg.sync_trigger_source_select ?
				any_hw : any_trig;
		end else begin
			reload = wrap;
		end
		stat = '0;
		stat.pend = s_q.pend;
		stat.pend_sw = s_q.pend_sw;
		stat.combined = combined;
	end

	always_comb begin
		s_d = s_q;
		s_d.trig_prev = i_hw_trig;
		s_d.cnt_prev = i_cnt.counter_value;
		s_d.prev_ok = 1'b1;

		// Pending deferred sync
		if (deferred) begin
			s_d.pend = 1'b0;
			s_d.pend_sw = 1'b0;
		end
		if (~imm & trig_for_load) begin
			s_d.pend = 1'b1;
			s_d.pend_sw = s_d.pend_sw | sw_fire;
		end

		// detected trigger clears its own enable only
		s_d.trig.hw_trigger_enable = s_q.trig.hw_trigger_enable
			& ~hw_fire;
		// sw request done at boundary or after immediate sync
		if ((deferred & s_q.pend_sw) | s_q.stb_sw) begin
			s_d.trig.sw_sync_request = 1'b0;
		end
		// a write lands after the clears, so it wins
		if (wr_trig) begin
			s_d.trig = wtrig;
			s_d.trig.rsvd = '0;
		end
		// selects only change by a write
		if (wr_cfg) begin
			s_d.cfg = pbs_cfg_t'(i_wdata);
		end
		if (i_wr & hit(i_addr, PBS_A_MASKBUF)) begin
			s_d.mbuf = i_wdata[NCH-1:0];
		end

		if (~s_q.cfg.mask_sync_enable) begin
			s_d.mask = s_q.mbuf;
		end else if (s_q.cfg.sync_trigger_source_select ?
			any_hw : any_trig) begin
			s_d.mask = s_q.mbuf;
		end

		// Strobes are registered, one cycle after the cause
		s_d.stb.period_load = ld_now & i_period_full;
		// compare loads follow the period timing
		s_d.cmp_ld = {NCH{ld_now & s_q.cfg.compare_sync_enable}}
			& i_cmp_full;
		// reload also forces initial channel levels
		s_d.stb.cnt_reload = reload;
		s_d.stb.force_init_out = reload;
		s_d.stb_sw = imm & sw_fire;

		s_d.rdata = PBS_ZERO;
		if (i_rd) begin
			case (i_addr)
				PBS_A_CFG: s_d.rdata = s_q.cfg;
				PBS_A_TRIG: s_d.rdata = s_q.trig;
				PBS_A_MASKBUF: s_d.rdata = PBS_DW'(s_q.mbuf);
				PBS_A_MASK: s_d.rdata = PBS_DW'(s_q.mask);
				PBS_A_STAT: s_d.rdata = stat;
				default: s_d.rdata = PBS_ZERO;
			endcase
		end
	end

	// Freeze on low clock enable keeps edge history coherent
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_q <= PBS_ST_RST;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_stb = s_q.stb;
	assign o_cmp_load = s_q.cmp_ld;
	assign o_output_mask = s_q.mask;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	a_hw_enable_clear: assert property (
		i_ce && hw_fire[0] && !wr_trig |=>
			!s_q.trig.hw_trigger_enable[0])
		else $error("hw enable not cleared on trigger");

	a_hw_write_keeps: assert property (
		i_ce && wr_trig && wtrig.hw_trigger_enable[0]
			&& edge_hw[0] && combined
			&& !s_q.cfg.sync_trigger_source_select |=>
			s_q.trig.hw_trigger_enable[0]
			&& (s_q.pend || s_q.stb.cnt_reload))
		else $error("write-set enable lost or sync skipped");

	a_sw_write_wins: assert property (
		i_ce && wr_trig && wtrig.sw_sync_request |=>
			s_q.trig.sw_sync_request)
		else $error("sw request lost against clear");

	a_mask_follows: assert property (
		i_ce && !s_q.cfg.mask_sync_enable |=>
			s_q.mask == $past(s_q.mbuf))
		else $error("unsynced mask not copied");

	a_no_select_load: assert property (
		i_ce && !s_q.cfg.min_boundary_select
			&& !s_q.cfg.max_boundary_select && !imm |=>
			!s_q.stb.period_load)
		else $error("load without boundary select");

	a_imm_period: assert property (
		i_ce && imm && any_trig && i_period_full |=>
			s_q.stb.period_load ##1 (!$past(i_ce)
			|| !s_q.stb.period_load
			|| $past(ld_now && i_period_full)))
		else $error("immediate period load missing");

	a_mode_gate: assert property (
		i_ce && !combined |=> !s_q.stb.period_load
			&& s_q.cmp_ld == '0)
		else $error("load outside combined mode");

	a_min_load: assert property (
		i_ce && s_q.pend && !imm && s_q.cfg.min_boundary_select
			&& at_min && s_q.prev_ok && combined
			&& i_period_full |=>
			s_q.stb.period_load
			&& (!s_q.pend || $past(trig_for_load)))
		else $error("min boundary load missing");

	a_hw_reload: assert property (
		i_ce && s_q.cfg.counter_reload_on_trigger && any_hw |=>
			s_q.stb.cnt_reload && s_q.stb.force_init_out)
		else $error("hw reload missing");

	a_select_kept: assert property (
		!wr_cfg |=> s_q.cfg == $past(s_q.cfg))
		else $error("boundary select changed by hardware");

	a_sw_imm_clear: assert property (
		i_ce && s_q.stb_sw && !wr_trig |=>
			!s_q.trig.sw_sync_request)
		else $error("sw request kept after immediate sync");

	a_zero_write_clears: assert property (
		i_ce && wr_trig && !wtrig.hw_trigger_enable[1] |=>
			!s_q.trig.hw_trigger_enable[1])
		else $error("hw enable kept after zero write");

	a_idle_enable_kept: assert property (
		i_ce && !wr_trig && !hw_fire[2]
			&& s_q.trig.hw_trigger_enable[2] |=>
			s_q.trig.hw_trigger_enable[2])
		else $error("hw enable lost without its trigger");

	a_max_load: assert property (
		i_ce && s_q.pend && !imm && s_q.cfg.max_boundary_select
			&& at_max && s_q.prev_ok && combined
			&& i_period_full |=> s_q.stb.period_load)
		else $error("max boundary load missing");

	a_cmp_gate: assert property (
		i_ce && !s_q.cfg.compare_sync_enable |=>
			s_q.cmp_ld == '0)
		else $error("compare load without sync enable");

	a_period_full_gate: assert property (
		i_ce && !i_period_full |=> !s_q.stb.period_load)
		else $error("period load with partial buffer");

	a_wrap_reload: assert property (
		i_ce && !s_q.cfg.counter_reload_on_trigger && wrap |=>
			s_q.stb.cnt_reload && s_q.stb.force_init_out)
		else $error("wrap reload missing");

	a_hw_only_reload: assert property (
		i_ce && s_q.cfg.counter_reload_on_trigger
			&& s_q.cfg.sync_trigger_source_select
			&& !any_hw |=> !s_q.stb.cnt_reload)
		else $error("reload without hw trigger");

	a_sync_mask_hold: assert property (
		i_ce && s_q.cfg.mask_sync_enable
			&& s_q.cfg.sync_trigger_source_select && !any_hw |=>
			s_q.mask == $past(s_q.mask))
		else $error("synced mask changed without hw trigger");

	a_sw_mask_load: assert property (
		i_ce && s_q.cfg.mask_sync_enable
			&& !s_q.cfg.sync_trigger_source_select && sw_fire |=>
			s_q.mask == $past(s_q.mbuf))
		else $error("synced mask not loaded on sw trigger");

	a_boundary_sw_clear: assert property (
		i_ce && deferred && s_q.pend_sw && !wr_trig |=>
			!s_q.trig.sw_sync_request)
		else $error("sw request kept after boundary");

	a_sw_only_pend: assert property (
		i_ce && s_q.cfg.sync_trigger_source_select && !sw_fire
			&& !s_q.pend |=> !s_q.pend)
		else $error("pending sync without sw trigger");

	c_imm_load: cover property (i_ce && imm && sw_fire
		##1 s_q.stb.period_load);
	c_deferred: cover property (s_q.pend && deferred && i_ce
		##1 s_q.stb.period_load);
	c_mask_sync: cover property (i_ce
		&& s_q.cfg.mask_sync_enable && any_hw);
	c_hw_write_keep: cover property (i_ce && wr_trig
		&& edge_hw[0] && wtrig.hw_trigger_enable[0]);
	c_wrap_reload: cover property (i_ce && wrap
		&& !s_q.cfg.counter_reload_on_trigger);

endmodule

// file: tb/pbs_timer_model.sv
// Timer counter and buffer status model facing the sync block
`timescale 1ns/1ps
module pbs_timer_model #(
	parameter logic [15:0] INIT = 16'h0004,
	parameter logic [15:0] PER = 16'h0013
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Counter state and buffer status
	output pbs_pkg::pbs_cnt_t o_cnt,
	output logic o_full,
	output logic [7:0] o_cmp_full
);
	import pbs_pkg::*;
	logic [15:0] cnt_q;
	// Up-counting only; both the wrap and the step up to PER are shown
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			cnt_q <= INIT;
		else if (cnt_q == PER)
			cnt_q <= INIT;
		else
			cnt_q <= cnt_q + 16'h0001;
	end
	assign o_cnt = {cnt_q, PER, INIT};
	// Upper channels left empty to show refusal
	assign o_full = 1'b1;
	assign o_cmp_full = 8'h0f;
endmodule

// file: tb/pbs_sync_tb.sv
// Self-checking bench for the buffered-update sync block
`timescale 1ns/1ps
module pbs_sync_tb;
	import pbs_pkg::*;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_ce = 1'b1;
	logic [PBS_AW-1:0] i_addr = '0;
	logic [PBS_DW-1:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [PBS_NTRIG-1:0] i_hw_trig = '0;
	logic [PBS_DW-1:0] o_rdata;
	pbs_cnt_t cnt;
	logic pfull;
	logic [7:0] cfull;
	pbs_strobe_t o_stb;
	logic [7:0] o_cmp_load;
	logic [7:0] o_output_mask;
	int error_cnt = 0;
	int cmp_count = 0;
	initial forever #10 i_clk = ~i_clk;
	pbs_sync u_pbs_sync (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_hw_trig(i_hw_trig), .i_cnt(cnt),
		.i_period_full(pfull), .i_cmp_full(cfull), .o_stb(o_stb),
		.o_cmp_load(o_cmp_load), .o_output_mask(o_output_mask));
	pbs_timer_model u_pbs_timer_model (.i_clk(i_clk), .i_rstn(i_rstn),
		.o_cnt(cnt), .o_full(pfull), .o_cmp_full(cfull));
	task automatic close_out();
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		check(o_rdata, e);
	endtask
	// Bounded wait for a counter value or a period load
	task automatic wait_for(input bit load, input logic [15:0] v);
		bit hit;
		hit = 1'b0;
		for (int i = 0; i < 100 && !hit; i++) begin
			@(posedge i_clk);
			#1;
			hit = load ? (o_stb.period_load === 1'b1)
				: (cnt.counter_value === v);
		end
		if (!hit) begin
			error_cnt++;
			close_out();
		end
	endtask
	task automatic pulse(input logic [2:0] t);
		@(posedge i_clk);
		i_hw_trig <= t;
		@(posedge i_clk);
		i_hw_trig <= 3'h0;
	endtask
	initial begin
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b1;
		rd(PBS_A_CFG, 8'h00);
		rd(PBS_A_TRIG, 8'h00);
		rd(3'h5, 8'h00);
		wr(PBS_A_MASKBUF, 8'ha5);
		repeat (2) @(posedge i_clk);
		rd(PBS_A_MASK, 8'ha5);
		// Immediate mode, pair not combined
		wr(PBS_A_CFG, 8'h64);
		wr(3'h6, 8'hff);
		rd(PBS_A_CFG, 8'h64);
		wr(PBS_A_TRIG, 8'h08);
		#1;
		check({5'h0, o_stb}, 8'h00);
		// Pair must be combined before a sw request counts
		wr(PBS_A_TRIG, 8'h20);
		wr(PBS_A_TRIG, 8'h28);
		#1;
		check({5'h0, o_stb}, 8'h07);
		check(o_cmp_load, 8'h0f);
		rd(PBS_A_TRIG, 8'h20);
		// Deferred hw load at the min boundary
		wr(PBS_A_CFG, 8'h41);
		wr(PBS_A_TRIG, 8'h21);
		wait_for(1'b0, 16'h0006);
		pulse(3'h1);
		rd(PBS_A_TRIG, 8'h20);
		rd(PBS_A_STAT, 8'h05);
		wait_for(1'b1, 16'h0000);
		check(cnt.counter_value[7:0], 8'h05);
		check({5'h0, o_stb}, 8'h07);
		check(o_cmp_load, 8'h00);
		rd(PBS_A_CFG, 8'h41);
		// Trigger edge meets the write that sets its enable
		@(posedge i_clk);
		i_hw_trig <= 3'h1;
		i_wr <= 1'b1;
		i_addr <= PBS_A_TRIG;
		i_wdata <= 8'h21;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_hw_trig <= 3'h0;
		rd(PBS_A_TRIG, 8'h21);
		rd(PBS_A_STAT, 8'h05);
		// Synced mask with hw-only source
		wr(PBS_A_CFG, 8'h58);
		wr(PBS_A_MASKBUF, 8'h3c);
		wr(PBS_A_TRIG, 8'h2c);
		repeat (3) @(posedge i_clk);
		rd(PBS_A_MASK, 8'ha5);
		pulse(3'h4);
		repeat (2) @(posedge i_clk);
		rd(PBS_A_MASK, 8'h3c);
		check(o_output_mask, 8'h3c);
		// Frozen block ignores a write
		@(posedge i_clk);
		i_ce <= 1'b0;
		wr(PBS_A_MASKBUF, 8'hff);
		i_ce <= 1'b1;
		rd(PBS_A_MASKBUF, 8'h3c);
		// Reset in mid-run clears state
		@(posedge i_clk);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		rd(PBS_A_MASK, 8'h00);
		rd(PBS_A_STAT, 8'h00);
		close_out();
	end
endmodule
